// ---- common/icache_pkg.sv ----
// constants and types shared by the instruction cache fill pipeline
package icache_pkg;
	// instruction word on the program memory data bus
	localparam int WORD_W = 48;
	// two-way set associative, sets indexed by the low address bits
	localparam int SET_BITS = 4;
	localparam int NUM_SETS = 16;
	localparam int NUM_WAYS = 2;
	// default fetch address width, arbitrary but plain
	localparam int ADDR_W_DEF = 24;
	// invalidate latency in instruction cycles
	localparam int FLUSH_LAT_INT = 1;
	localparam int FLUSH_LAT_EXT = 2;
	localparam int FLUSH_CNT_W = 2;
	localparam logic [1:0] FLUSH_CNT_RST = 2'h0;
	localparam logic [1:0] FLUSH_CNT_FIRE = 2'h1;
	// fetch sequencing: normal run or the stall slot after a conflict miss
	typedef enum {st_run, st_retry} fetch_st_t;
endpackage

// ---- core/icache_fill.sv ----
// instruction cache with fetch1 lookup, fetch2 read and decode fill
`timescale 1ns/10ps
module icache_fill #(
	parameter int ADDR_W = icache_pkg::ADDR_W_DEF,
	parameter int WORD_W = icache_pkg::WORD_W
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic fetch_valid,
	input wire logic [ADDR_W-1:0] fetch_addr,
	input wire logic fetch_ext,
	input wire logic program_memory_data_access,
	input wire logic cache_disable,
	input wire logic cache_freeze,
	input wire logic flush_req,
	input wire logic [WORD_W-1:0] mem_word,
	output logic lookup,
	output logic hit,
	output logic stall,
	output logic mem_fetch,
	output logic [WORD_W-1:0] instr_word,
	output logic instr_valid,
	output logic instr_from_cache
);
	localparam int SB = icache_pkg::SET_BITS;
	localparam int NS = icache_pkg::NUM_SETS;
	localparam int NW = icache_pkg::NUM_WAYS;
	localparam int TAG_W = ADDR_W - SB;

	// set index must fit the table and leave a tag
	if (ADDR_W <= SB || NS != (1 << SB) || NW != 2 ||
	    WORD_W != icache_pkg::WORD_W) begin : g_bad
		$error("icache_fill: unsupported parameters");
	end

	function automatic logic [SB-1:0] set_of(input logic [ADDR_W-1:0] a);
		set_of = a[SB-1:0];
	endfunction

	function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
		tag_of = a[ADDR_W-1:SB];
	endfunction

	// cache storage; tags and words carry no reset
	logic [TAG_W-1:0] tag_ff [NW][NS];
	logic [TAG_W-1:0] nxt_tag [NW][NS];
	logic [WORD_W-1:0] data_ff [NW][NS];
	logic [WORD_W-1:0] nxt_data [NW][NS];
	logic [NW-1:0][NS-1:0] valid_ff, nxt_valid;
	logic [NS-1:0] lru_ff, nxt_lru;

	icache_pkg::fetch_st_t st_ff, nxt_st;
	logic hold_way_ff, nxt_hold_way;
	logic hold_fill_ff, nxt_hold_fill;
	logic [icache_pkg::FLUSH_CNT_W-1:0] flush_cnt_ff, nxt_flush_cnt;

	// fetch2 stage
	logic f2_valid_ff, nxt_f2_valid;
	logic f2_hit_ff, nxt_f2_hit;
	logic f2_fill_ff, nxt_f2_fill;
	logic f2_way_ff, nxt_f2_way;
	logic [SB-1:0] f2_set_ff, nxt_f2_set;
	// decode stage fill, the cache's incoming load bus
	logic dec_wr_ff, nxt_dec_wr;
	logic dec_way_ff, nxt_dec_way;
	logic [SB-1:0] dec_set_ff, nxt_dec_set;
	logic [WORD_W-1:0] dec_word_ff, nxt_dec_word;
	// delivered instruction
	logic [WORD_W-1:0] instr_word_ff, nxt_instr_word;
	logic instr_valid_ff, nxt_instr_valid;
	logic from_cache_ff, nxt_from_cache;

	logic in_retry, enabled, fill_ok, capture, victim, hit_way;
	logic launch, flush_now, fwd;
	logic [NW-1:0] match;
	logic [SB-1:0] set_idx;
	logic [TAG_W-1:0] tag_idx;

	// fetch1 lookup, combinational so a hit avoids the stall
	always_comb begin
		set_idx = set_of(fetch_addr);
		tag_idx = tag_of(fetch_addr);
		in_retry = (st_ff == icache_pkg::st_retry);
		enabled = !cache_disable;
		fill_ok = enabled && !cache_freeze;
		// internal only on a conflict, external every time
		lookup = fetch_valid && enabled && !in_retry && (fetch_ext ||
		    program_memory_data_access);
		for (int w = 0; w < NW; w++) begin
			match[w] = valid_ff[w][set_idx] &&
			    (tag_ff[w][set_idx] == tag_idx);
		end
		hit = lookup && (match != '0);
		hit_way = match[1];
		victim = lru_ff[set_idx];
		capture = lookup && !hit && fill_ok;
		// a conflict miss waits out the data access
		stall = lookup && !hit && !fetch_ext &&
		    program_memory_data_access;
		// a hit rides beside the data access
		mem_fetch = fetch_valid && !hit && !stall;
		launch = fetch_valid && !stall;
	end

	// stall slot and the entry it will fill
	always_comb begin
		nxt_st = stall ? icache_pkg::st_retry : icache_pkg::st_run;
		nxt_hold_way = stall ? victim : hold_way_ff;
		nxt_hold_fill = stall ? capture : hold_fill_ff;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_ff <= icache_pkg::st_run;
			hold_way_ff <= 1'b0;
			hold_fill_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			hold_way_ff <= nxt_hold_way;
			hold_fill_ff <= nxt_hold_fill;
		end
	end

	// invalidate delay; enable bit deliberately not consulted
	always_comb begin
		int lat;
		lat = fetch_ext ? icache_pkg::FLUSH_LAT_EXT : icache_pkg::FLUSH_LAT_INT;
		nxt_flush_cnt = flush_cnt_ff;
		if (flush_req) begin
			nxt_flush_cnt = icache_pkg::FLUSH_CNT_W'(lat - 1);
		end else if (flush_cnt_ff != icache_pkg::FLUSH_CNT_RST) begin
			nxt_flush_cnt = flush_cnt_ff - icache_pkg::FLUSH_CNT_FIRE;
		end
		flush_now = (flush_req && lat == 1) ||
		    (flush_cnt_ff == icache_pkg::FLUSH_CNT_FIRE);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			flush_cnt_ff <= icache_pkg::FLUSH_CNT_RST;
		end else begin
			flush_cnt_ff <= nxt_flush_cnt;
		end
	end

	// fetch2 and decode stage advance
	always_comb begin
		nxt_f2_valid = launch;
		nxt_f2_hit = hit;
		nxt_f2_set = set_idx;
		nxt_f2_way = in_retry ? hold_way_ff : (hit ? hit_way : victim);
		nxt_f2_fill = in_retry ? hold_fill_ff : capture;
		// fill still in decode: array not yet written
		fwd = f2_hit_ff && dec_wr_ff && dec_way_ff == f2_way_ff &&
		    dec_set_ff == f2_set_ff;
		nxt_instr_word = instr_word_ff;
		if (f2_valid_ff) begin
			if (!f2_hit_ff) begin
				nxt_instr_word = mem_word;
			end else if (fwd) begin
				nxt_instr_word = dec_word_ff;
			end else begin
				nxt_instr_word = data_ff[f2_way_ff][f2_set_ff];
			end
		end
		nxt_instr_valid = f2_valid_ff;
		nxt_from_cache = f2_valid_ff && f2_hit_ff;
		nxt_dec_wr = f2_valid_ff && !f2_hit_ff && f2_fill_ff;
		nxt_dec_word = mem_word;
		nxt_dec_way = f2_way_ff;
		nxt_dec_set = f2_set_ff;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			f2_valid_ff <= 1'b0;
			f2_hit_ff <= 1'b0;
			f2_fill_ff <= 1'b0;
			f2_way_ff <= 1'b0;
			f2_set_ff <= '0;
			dec_wr_ff <= 1'b0;
			dec_way_ff <= 1'b0;
			dec_set_ff <= '0;
			dec_word_ff <= '0;
			instr_word_ff <= '0;
			instr_valid_ff <= 1'b0;
			from_cache_ff <= 1'b0;
		end else begin
			f2_valid_ff <= nxt_f2_valid;
			f2_hit_ff <= nxt_f2_hit;
			f2_fill_ff <= nxt_f2_fill;
			f2_way_ff <= nxt_f2_way;
			f2_set_ff <= nxt_f2_set;
			dec_wr_ff <= nxt_dec_wr;
			dec_way_ff <= nxt_dec_way;
			dec_set_ff <= nxt_dec_set;
			dec_word_ff <= nxt_dec_word;
			instr_word_ff <= nxt_instr_word;
			instr_valid_ff <= nxt_instr_valid;
			from_cache_ff <= nxt_from_cache;
		end
	end

	assign instr_word = instr_word_ff;
	assign instr_valid = instr_valid_ff;
	assign instr_from_cache = from_cache_ff;

	// array update; a same-cycle capture survives the invalidate
	always_comb begin
		nxt_tag = tag_ff;
		nxt_data = data_ff;
		nxt_valid = valid_ff;
		nxt_lru = lru_ff;
		if (flush_now) begin
			nxt_valid = '0;
		end
		if (capture) begin
			nxt_tag[victim][set_idx] = tag_idx;
			nxt_valid[victim][set_idx] = 1'b1;
			nxt_lru[set_idx] = !victim;
		end
		if (hit) begin
			nxt_lru[set_idx] = !hit_way;
		end
		if (dec_wr_ff) begin
			nxt_data[dec_way_ff][dec_set_ff] = dec_word_ff;
		end
	end

	// only recency and valid bits need a reset value
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			valid_ff <= '0;
			lru_ff <= '0;
		end else begin
			valid_ff <= nxt_valid;
			lru_ff <= nxt_lru;
		end
	end

	always_ff @(posedge clk_sys) begin
		tag_ff <= nxt_tag;
		data_ff <= nxt_data;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	ext_lookup_a: assert property (
	    fetch_valid && fetch_ext && !cache_disable && !in_retry |-> lookup)
		else $error("external fetch skipped the hit check");
	int_quiet_a: assert property (
	    !fetch_ext && !program_memory_data_access |-> !lookup && !stall)
		else $error("internal lookup without conflict");
	fill_entry_a: assert property (
	    capture && !flush_now |=>
	    valid_ff[$past(victim)][$past(set_idx)] &&
	    tag_ff[$past(victim)][$past(set_idx)] == $past(tag_idx))
		else $error("missed address not loaded into cache");
	lru_flip_a: assert property (
	    capture |=> lru_ff[$past(set_idx)] == !$past(victim))
		else $error("recency bit not moved after fill");
	decode_fill_a: assert property (
	    f2_valid_ff && !f2_hit_ff && f2_fill_ff |=> dec_wr_ff ##1
	    data_ff[$past(dec_way_ff)][$past(dec_set_ff)] ==
	    $past(mem_word, 2))
		else $error("miss word not written in decode");
	fwd_word_a: assert property (
	    f2_valid_ff && fwd |=>
	    instr_word == $past(dec_word_ff) && instr_from_cache)
		else $error("forwarded word wrong");
	miss_word_a: assert property (
	    f2_valid_ff && !f2_hit_ff |=>
	    instr_word == $past(mem_word) && !instr_from_cache)
		else $error("miss word not from memory bus");
	stall_once_a: assert property (
	    stall |=> in_retry && !stall && !lookup ##1 !in_retry)
		else $error("conflict miss stall not one cycle");
	hit_nostall_a: assert property (
	    hit |-> !stall && mem_fetch == 1'b0)
		else $error("hit stalled the pipeline");
	freeze_a: assert property (
	    cache_freeze || cache_disable |-> !capture)
		else $error("fill while frozen or disabled");
	flush_int_a: assert property (
	    flush_req && !fetch_ext && !capture |=> valid_ff == '0)
		else $error("internal invalidate late");
	flush_ext_a: assert property (
	    flush_req && fetch_ext && !capture ##1 !capture |=>
	    valid_ff == '0)
		else $error("external invalidate late");

	// stall, retry launch, fetch2, then the word is delivered
	hit_c: cover property (hit && program_memory_data_access && !fetch_ext);
	fwd_c: cover property (f2_valid_ff && fwd);
	stall_c: cover property (stall ##3 instr_valid);
	flush_c: cover property (flush_req && cache_disable && fetch_ext);
endmodule

// ---- test/icache_mem_model.sv ----
// program memory model answering fetches routed to memory
`timescale 1ns/10ps
module icache_mem_model (
	input wire logic clk_sys,
	input wire logic mem_fetch,
	input wire logic [23:0] fetch_addr,
	output logic [47:0] mem_word
);
	// word shows in fetch2, the cycle after the memory fetch request
	// otherwise the bus is not driven: toggle so stale data never matches
	initial mem_word = 48'h0;
	always @(posedge clk_sys) begin
		if (mem_fetch === 1'b1)
			mem_word <= {~fetch_addr, fetch_addr};
		else
			mem_word <= ~mem_word;
	end
endmodule

// ---- test/instruction_cache_pipeline_fill_tb.sv ----
// self-checking bench for the instruction cache fill pipeline
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module instruction_cache_pipeline_fill_tb;
	logic clk_sys, srst, fetch_valid, fetch_ext;
	logic program_memory_data_access;
	logic cache_disable, cache_freeze, flush_req;
	logic [23:0] fetch_addr;
	logic [47:0] mem_word, instr_word;
	logic lookup, hit, stall, mem_fetch, instr_valid, instr_from_cache;
	logic [48:0] exp_q[$];
	logic [48:0] note;
	logic [15:0] rnd;
	logic [23:0] a, b, c, d, x, y, z;
	int err_count, num_checks, cycles;
	icache_fill i_dut (.clk_sys(clk_sys), .srst(srst),
		.fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
		.fetch_ext(fetch_ext),
		.program_memory_data_access(program_memory_data_access),
		.cache_disable(cache_disable), .cache_freeze(cache_freeze),
		.flush_req(flush_req), .mem_word(mem_word), .lookup(lookup),
		.hit(hit), .stall(stall), .mem_fetch(mem_fetch),
		.instr_word(instr_word), .instr_valid(instr_valid),
		.instr_from_cache(instr_from_cache));
	icache_mem_model i_mem (.clk_sys(clk_sys), .mem_fetch(mem_fetch),
		.fetch_addr(fetch_addr), .mem_word(mem_word));
	// 20 mhz core clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// random tag from the lfsr, set index chosen by the caller
	function automatic logic [23:0] mk(input logic [3:0] set);
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		return {4'h0, rnd, set};
	endfunction
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one fetch launch; exp is {lookup, hit, stall}; holds valid high
	task automatic fetch(input logic [23:0] ad, input logic ext, conf,
		input logic [2:0] exp);
		fetch_valid <= 1'b1;
		fetch_addr <= ad;
		fetch_ext <= ext;
		program_memory_data_access <= conf;
		@(negedge clk_sys);
		`CHK({lookup, hit, stall}, exp)
		`CHK(mem_fetch, ~exp[1] & ~exp[0])
		if (!exp[0])
			exp_q.push_back({exp[1], ~ad, ad});
		@(posedge clk_sys);
	endtask
	task automatic idle(input int n);
		fetch_valid <= 1'b0;
		program_memory_data_access <= 1'b0;
		repeat (n) @(posedge clk_sys);
	endtask
	// invalidate pulse; no pm data access may follow it directly
	task automatic flush(input logic ext, dis);
		flush_req <= 1'b1;
		fetch_ext <= ext;
		cache_disable <= dis;
		fetch_valid <= 1'b0;
		program_memory_data_access <= 1'b0;
		@(posedge clk_sys);
		flush_req <= 1'b0;
		cache_disable <= 1'b0;
	endtask
	// result watcher: oldest note against each delivered word
	always @(negedge clk_sys) begin
		if (instr_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				`CHK(instr_valid, 1'b0)
			end else begin
				note = exp_q.pop_front();
				`CHK({instr_from_cache, instr_word}, note)
			end
		end
	end
	// hang guard, far above the 63 cycles of the sequence
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles > 3000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		rnd = 16'h82e4;
		err_count = 0;
		num_checks = 0;
		cycles = 0;
		srst = 1'b1;
		{fetch_valid, fetch_ext, flush_req} = 3'h0;
		program_memory_data_access = 1'b0;
		{cache_disable, cache_freeze} = 2'h0;
		fetch_addr = 24'h0;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		a = mk(4'h1); b = mk(4'h2); c = mk(4'h3); d = mk(4'h5);
		x = mk(4'h4); y = mk(4'h4); z = mk(4'h4);
		// external miss, later hit; then miss with hit right behind
		fetch(a, 1'b1, 1'b0, 3'h4); idle(3);
		fetch(a, 1'b1, 1'b1, 3'h6);
		fetch(b, 1'b1, 1'b0, 3'h4);
		fetch(b, 1'b1, 1'b0, 3'h6); idle(3);
		// internal: no compare without conflict, conflict hit and miss
		fetch(a, 1'b0, 1'b0, 3'h0);
		fetch(a, 1'b0, 1'b1, 3'h6);
		fetch(c, 1'b0, 1'b1, 3'h5);
		fetch(c, 1'b0, 1'b0, 3'h0); idle(3);
		fetch(c, 1'b0, 1'b1, 3'h6); idle(3);
		// two ways per set, least recently used entry is replaced
		fetch(x, 1'b1, 1'b0, 3'h4); fetch(y, 1'b1, 1'b0, 3'h4);
		idle(3); fetch(x, 1'b1, 1'b0, 3'h6);
		fetch(z, 1'b1, 1'b0, 3'h4); idle(3);
		fetch(x, 1'b1, 1'b0, 3'h6); fetch(y, 1'b1, 1'b0, 3'h4);
		idle(3);
		// frozen misses leave no entry; disabled makes no compare
		cache_freeze <= 1'b1;
		fetch(d, 1'b1, 1'b0, 3'h4); idle(3);
		fetch(d, 1'b1, 1'b0, 3'h4); idle(3);
		cache_freeze <= 1'b0;
		cache_disable <= 1'b1;
		fetch(a, 1'b1, 1'b0, 3'h0); idle(1);
		// external invalidate while disabled: two cycles to take hold
		flush(1'b1, 1'b1);
		fetch(a, 1'b1, 1'b0, 3'h6);
		fetch(a, 1'b1, 1'b0, 3'h4); idle(3);
		// internal invalidate: one cycle
		flush(1'b0, 1'b0);
		fetch(a, 1'b1, 1'b0, 3'h4); idle(6);
		`CHK(exp_q.size(), 0)
		report_and_stop();
	end
endmodule
